/* common/fan_tach_pkg.sv */
// Constants and types shared by the fan speed measurement block
package fan_tach_pkg;

   // ----------------------------------------------------------------
   // Clocks
   // ----------------------------------------------------------------
   localparam int unsigned CORE_CLK_HZ = 20_000_000;
   localparam int unsigned REF_CLK_HZ  = 90_000;
   // Rounded down: reference runs marginally fast, never slow
   localparam int unsigned REF_DIV     = CORE_CLK_HZ / REF_CLK_HZ;

   // ----------------------------------------------------------------
   // Register offsets (reading has no printed offset)
   // ----------------------------------------------------------------
   localparam logic [7:0] TACH_INPUT_OPTIONS_OFS   = 8'h90;
   localparam logic [7:0] DRIVE_OUTPUT_OPTIONS_OFS = 8'h94;

   // ----------------------------------------------------------------
   // Tach and drive option fields
   // ----------------------------------------------------------------
   localparam int unsigned TOPT_MODE_BIT   = 0;
   localparam int unsigned TOPT_EDGES_LSB  = 1;
   localparam int unsigned TOPT_GUARD_LSB  = 3;
   localparam int unsigned TOPT_SLOW_BIT   = 5;
   localparam int unsigned TOPT_IGNORE_BIT = 6;
   localparam logic [7:0]  TOPT_RESET      = 8'h15;
   localparam int unsigned DOPT_UPDATE_LSB = 0;
   localparam logic [7:0]  DOPT_RESET      = 8'h02;

   // ----------------------------------------------------------------
   // Edge counts and guard times by field code
   // ----------------------------------------------------------------
   localparam logic [3:0] EDGES_2 = 4'h2;
   localparam logic [3:0] EDGES_3 = 4'h3;
   localparam logic [3:0] EDGES_5 = 4'h5;
   localparam logic [3:0] EDGES_9 = 4'h9;
   localparam logic [5:0] GUARD_8  = 6'h08;
   localparam logic [5:0] GUARD_16 = 6'h10;
   localparam logic [5:0] GUARD_32 = 6'h20;
   localparam logic [5:0] GUARD_63 = 6'h3F;
   localparam logic [1:0] SKIP_EDGES = 2'h3;

   // ----------------------------------------------------------------
   // Readings and update intervals
   // ----------------------------------------------------------------
   localparam logic [15:0] READ_STALL = 16'hFFFF;
   localparam logic [15:0] READ_SLOW  = 16'hFFFE;
   localparam logic [15:0] COUNT_MAX  = 16'hFFFF;
   localparam int unsigned UPDATE_300_MS  = 300;
   localparam int unsigned UPDATE_500_MS  = 500;
   localparam int unsigned UPDATE_1000_MS = 1000;
   localparam int unsigned UPDATE_300_TICKS  = UPDATE_300_MS * REF_CLK_HZ / 1000;
   localparam int unsigned UPDATE_500_TICKS  = UPDATE_500_MS * REF_CLK_HZ / 1000;
   localparam int unsigned UPDATE_1000_TICKS = UPDATE_1000_MS * REF_CLK_HZ / 1000;

   typedef enum logic [5:0] {
      ST_IDLE  = 6'h01,
      ST_DRIVE = 6'h02,
      ST_GUARD = 6'h04,
      ST_SKIP  = 6'h08,
      ST_FIRST = 6'h10,
      ST_COUNT = 6'h20
   } meas_state_t;

endpackage

/* common/tach_event_if.sv */
// Filtered tach level and edge events between filter and measurement
`timescale 1ns/100ps
`default_nettype none
interface tach_event_if;
   logic ref_tick;
   logic edge_seen;
   logic level;
   modport source (input ref_tick, output edge_seen, output level);
   modport sink   (output ref_tick, input edge_seen, input level);
endinterface
`default_nettype wire

/* design/tach_glitch_filter.sv */
// Synchroniser and glitch filter for one tach input
`timescale 1ns/100ps
`default_nettype none
module tach_glitch_filter #(
   parameter int unsigned FILTER_LEN = 3
) (
   // Clock and reset
   input  wire logic   core_clk,
   input  wire logic   reset_n,
   // Tach pin
   input  wire logic   fan_speed_input_n,
   // Events toward measurement
   tach_event_if.source evt
);
   logic                  sync_a;
   logic                  sync_b;
   logic [FILTER_LEN-1:0] history;
   logic [FILTER_LEN-1:0] next_history;
   logic                  level;
   logic                  next_level;
   logic                  edge_seen;
   logic                  next_edge_seen;

   // ----------------------------------------------------------------
   // Filter
   // ----------------------------------------------------------------
   always_comb begin
      next_history   = history;
      next_level     = level;
      next_edge_seen = 1'b0;
      // Sampled only on reference ticks so edges share the count domain
      if (evt.ref_tick) begin
         next_history = {history[FILTER_LEN-2:0], sync_b};
         // Level moves only after FILTER_LEN agreeing samples
         if (&next_history && !level) begin
            next_level     = 1'b1;
            next_edge_seen = 1'b1;
         end else if (!(|next_history) && level) begin
            next_level     = 1'b0;
            next_edge_seen = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         sync_a    <= 1'b0;
         sync_b    <= 1'b0;
         history   <= '0;
         level     <= 1'b0;
         edge_seen <= 1'b0;
      end else begin
         sync_a    <= fan_speed_input_n;
         sync_b    <= sync_a;
         history   <= next_history;
         level     <= next_level;
         edge_seen <= next_edge_seen;
      end
   end

   assign evt.level     = level;
   assign evt.edge_seen = edge_seen;
endmodule // tach_glitch_filter
`default_nettype wire

/* design/fan_tach_speed_measure.sv */
// Fan speed measurement for one tach input with linkable drive gating
`timescale 1ns/100ps
`default_nettype none

//Behaviour
// - Mode 1 counts reference pulses across edges
// - Mode 1 refreshes after every measurement
// - Count from first edge to last or saturation
// - Full edges by saturation load the count
// - Saturation with no edge reads all ones
// - Saturation with some edges gives slow code
// - Pulsed mode measures only while drive high
// - Pulsed start after drive rise and guard
// - No edge while drive high reads stalled
// - Too few edges while drive high: slow
// - Full edges within drive high latch count
// - Final edge ends detection, state idles, loads
// - Edge count 2, 3, 5 or 9
// - Guard time selectable within 8 to 63
// - Optional discard of first three edges in pulsed mode
// - Pulsed update every 300, 500, 1000 ms
// - Byte reads freeze the other byte
// - Reading ignores writes
// - Both tach transitions count as edges
// - Any tach may link any drive output
// - Mode bit: 0 always, 1 pulsed
// - Glitch filter ahead of edge detection
module fan_tach_speed_measure
   import fan_tach_pkg::*;
#(
   parameter int unsigned NUM_DRIVES   = 3,
   parameter int unsigned FILTER_LEN   = 3,
   parameter int unsigned TICKS_300MS  = UPDATE_300_TICKS,
   parameter int unsigned TICKS_500MS  = UPDATE_500_TICKS,
   parameter int unsigned TICKS_1000MS = UPDATE_1000_TICKS
) (
   // Clock and reset
   input  wire logic                    core_clk,
   input  wire logic                    reset_n,
   // Fan pins and drive outputs
   input  wire logic                    fan_speed_input_n,
   input  wire logic [NUM_DRIVES-1:0]   fan_drive_output_n,
   // Option registers
   input  wire logic [7:0]              tach_input_options,
   input  wire logic [NUM_DRIVES*8-1:0] drive_output_options,
   input  wire logic [1:0]              drive_link_select,
   // Reading register byte reads
   input  wire logic                    read_low_strobe,
   input  wire logic                    read_high_strobe,
   output logic [7:0]                   reading_low_byte,
   output logic [7:0]                   reading_high_byte,
   // Status
   output logic [15:0]                  tach_period_reading,
   output logic                         fan_stalled,
   output logic                         fan_slow
);
   import fan_tach_pkg::*;

   localparam logic [7:0] REF_DIV_LAST = 8'(REF_DIV - 1);

   tach_event_if evt ();

   meas_state_t state;
   meas_state_t next_state;
   logic [7:0]  ref_div;
   logic [7:0]  next_ref_div;
   logic [15:0] count;
   logic [15:0] next_count;
   logic [3:0]  edges;
   logic [3:0]  next_edges;
   logic [1:0]  skipped;
   logic [1:0]  next_skipped;
   logic [5:0]  guard;
   logic [5:0]  next_guard;
   logic [16:0] interval;
   logic [16:0] next_interval;
   logic        drive_prev;
   logic [15:0] reading;
   logic [15:0] next_reading;
   logic        stalled;
   logic        next_stalled;
   logic        slow;
   logic        next_slow;
   logic        hold_low;
   logic        next_hold_low;
   logic        hold_high;
   logic        next_hold_high;
   logic [7:0]  low_out;
   logic [7:0]  next_low_out;
   logic [7:0]  high_out;
   logic [7:0]  next_high_out;

   logic        ref_tick;
   logic        pulsed_mode;
   logic        slow_sel;
   logic [3:0]  edge_target;
   logic [5:0]  guard_target;
   logic [16:0] interval_target;
   logic [7:0]  linked_opt;
   logic        drive_high;
   logic        drive_rise;
   logic        saturated;
   logic [15:0] short_code;

   // ----------------------------------------------------------------
   // Filter
   // ----------------------------------------------------------------
   tach_glitch_filter #(
      .FILTER_LEN (FILTER_LEN)
   ) u_filter (
      .core_clk          (core_clk),
      .reset_n           (reset_n),
      .fan_speed_input_n (fan_speed_input_n),
      .evt               (evt.source)
   );

   assign evt.ref_tick = ref_tick;

   // ----------------------------------------------------------------
   // Option decode
   // ----------------------------------------------------------------
   always_comb begin
      // Drive outputs come from on-chip logic, so no synchroniser
      drive_high  = fan_drive_output_n[drive_link_select];
      linked_opt  = drive_output_options[drive_link_select*8 +: 8];
      pulsed_mode = tach_input_options[TOPT_MODE_BIT];
      slow_sel    = tach_input_options[TOPT_SLOW_BIT];
      case (tach_input_options[TOPT_EDGES_LSB +: 2])
         2'h0:    edge_target = EDGES_2;
         2'h1:    edge_target = EDGES_3;
         2'h2:    edge_target = EDGES_5;
         default: edge_target = EDGES_9;
      endcase
      case (tach_input_options[TOPT_GUARD_LSB +: 2])
         2'h0:    guard_target = GUARD_8;
         2'h1:    guard_target = GUARD_16;
         2'h2:    guard_target = GUARD_32;
         default: guard_target = GUARD_63;
      endcase
      case (linked_opt[DOPT_UPDATE_LSB +: 2])
         2'h0:    interval_target = 17'(TICKS_300MS);
         2'h1:    interval_target = 17'(TICKS_500MS);
         default: interval_target = 17'(TICKS_1000MS);
      endcase
      drive_rise = drive_high && !drive_prev;
      saturated  = ref_tick && (count == COUNT_MAX);
      short_code = slow_sel ? READ_STALL : READ_SLOW;
   end

   // ----------------------------------------------------------------
   // Measurement
   // ----------------------------------------------------------------
   always_comb begin
      ref_tick      = (ref_div == REF_DIV_LAST);
      next_ref_div  = ref_tick ? 8'h00 : ref_div + 8'h01;
      next_state    = state;
      next_count    = count;
      next_edges    = edges;
      next_skipped  = skipped;
      next_guard    = guard;
      next_reading  = reading;
      next_stalled  = stalled;
      next_slow     = slow;
      next_interval = interval;
      if (ref_tick && interval != 17'h00000) begin
         next_interval = interval - 17'h00001;
      end
      case (state)
         ST_IDLE: begin
            next_count = 16'h0000;
            next_edges = 4'h0;
            next_state = pulsed_mode ? ST_DRIVE : ST_FIRST;
         end
         ST_DRIVE: begin
            // Wait out the update interval, then a fresh drive rise
            if (interval == 17'h00000 && drive_rise) begin
               next_guard = 6'h00;
               next_state = ST_GUARD;
            end
         end
         ST_GUARD: begin
            if (!drive_high) begin
               // Drive dropped inside guard; no usable window
               next_state = ST_DRIVE;
            end else if (ref_tick) begin
               next_guard = guard + 6'h01;
               if (next_guard == guard_target) begin
                  next_skipped = 2'h0;
                  next_state   = tach_input_options[TOPT_IGNORE_BIT] ? ST_SKIP
                                                                      : ST_FIRST;
               end
            end
         end
         ST_SKIP: begin
            if (!drive_high) begin
               next_reading  = READ_STALL;
               next_stalled  = 1'b1;
               next_slow     = 1'b0;
               next_interval = interval_target;
               next_state    = ST_IDLE;
            end else if (evt.edge_seen) begin
               next_skipped = skipped + 2'h1;
               if (next_skipped == SKIP_EDGES) begin
                  next_state = ST_FIRST;
               end
            end
         end
         ST_FIRST: begin
            // Count runs before the first edge so a dead fan saturates
            if (ref_tick && count != COUNT_MAX) begin
               next_count = count + 16'h0001;
            end
            if (pulsed_mode && !drive_high) begin
               next_reading  = READ_STALL;
               next_stalled  = 1'b1;
               next_slow     = 1'b0;
               next_interval = interval_target;
               next_state    = ST_IDLE;
            end else if (evt.edge_seen) begin
               next_count = 16'h0000;
               next_edges = 4'h1;
               next_state = ST_COUNT;
            end else if (saturated) begin
               next_reading = READ_STALL;
               next_stalled = 1'b1;
               next_slow    = 1'b0;
               next_state   = ST_IDLE;
            end
         end
         ST_COUNT: begin
            if (ref_tick && count != COUNT_MAX) begin
               next_count = count + 16'h0001;
            end
            if (pulsed_mode && !drive_high) begin
               next_reading  = short_code;
               next_stalled  = 1'b0;
               next_slow     = 1'b1;
               next_interval = interval_target;
               next_state    = ST_IDLE;
            end else if (evt.edge_seen && edges + 4'h1 == edge_target) begin
               next_reading  = count;
               next_stalled  = 1'b0;
               next_slow     = 1'b0;
               next_interval = interval_target;
               next_state    = ST_IDLE;
            end else if (evt.edge_seen) begin
               next_edges = edges + 4'h1;
            end else if (saturated) begin
               next_reading = short_code;
               next_stalled = 1'b0;
               next_slow    = 1'b1;
               next_state   = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Byte freeze
   // ----------------------------------------------------------------
   always_comb begin
      // Reading has no write path at all
      next_hold_low  = hold_low;
      next_hold_high = hold_high;
      if (read_low_strobe) begin
         next_hold_high = 1'b1;
         next_hold_low  = 1'b0;
      end else if (read_high_strobe) begin
         next_hold_low  = !hold_high;
         next_hold_high = 1'b0;
      end
      next_low_out  = next_hold_low ? low_out : reading[7:0];
      next_high_out = next_hold_high ? high_out : reading[15:8];
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state      <= ST_IDLE;
         ref_div    <= 8'h00;
         count      <= 16'h0000;
         edges      <= 4'h0;
         skipped    <= 2'h0;
         guard      <= 6'h00;
         interval   <= 17'h00000;
         drive_prev <= 1'b0;
         reading    <= READ_STALL;
         stalled    <= 1'b0;
         slow       <= 1'b0;
         hold_low   <= 1'b0;
         hold_high  <= 1'b0;
         low_out    <= 8'h00;
         high_out   <= 8'h00;
      end else begin
         state      <= next_state;
         ref_div    <= next_ref_div;
         count      <= next_count;
         edges      <= next_edges;
         skipped    <= next_skipped;
         guard      <= next_guard;
         interval   <= next_interval;
         drive_prev <= drive_high;
         reading    <= next_reading;
         stalled    <= next_stalled;
         slow       <= next_slow;
         hold_low   <= next_hold_low;
         hold_high  <= next_hold_high;
         low_out    <= next_low_out;
         high_out   <= next_high_out;
      end
   end

   assign reading_low_byte    = low_out;
   assign reading_high_byte   = high_out;
   assign tach_period_reading = reading;
   assign fan_stalled         = stalled;
   assign fan_slow            = slow;
endmodule // fan_tach_speed_measure
`default_nettype wire

/* sim/fan_tach_model.sv */
// Behavioural fan: tach square wave while powered, floating pattern while not
`timescale 1ns/100ps
`default_nettype none
module fan_tach_model (
   // Clock
   input  wire logic        core_clk,
   // Fan supply and speed
   input  wire logic        powered,
   input  wire logic [15:0] half_cycles,
   // Tach pin
   output var  logic        fan_speed_input_n
);
   logic [15:0] cnt = 16'h0000;
   initial fan_speed_input_n = 1'h0;
   // ----------------------------------------------------------------
   // Rotor
   // ----------------------------------------------------------------
   always @(posedge core_clk) begin
      if (!powered) begin
         // Unpowered tach floats, so never show a clean level
         fan_speed_input_n <= ~fan_speed_input_n;
         cnt               <= 16'h0000;
      end else if (half_cycles == 16'h0000) begin
         cnt <= 16'h0000;
      end else if (cnt + 16'h0001 >= half_cycles) begin
         cnt               <= 16'h0000;
         fan_speed_input_n <= ~fan_speed_input_n;
      end else begin
         cnt <= cnt + 16'h0001;
      end
   end
endmodule // fan_tach_model
`default_nettype wire

/* sim/fan_tach_speed_measure_properties.sv */
// Port-level checker for the fan speed measurement block
`timescale 1ns/100ps
`default_nettype none
module fan_tach_measure_checker #(
   parameter int unsigned NUM_DRIVES = 3
) (
   // Clock and reset
   input  wire logic                    core_clk,
   input  wire logic                    reset_n,
   // Pins and options
   input  wire logic                    fan_speed_input_n,
   input  wire logic [NUM_DRIVES-1:0]   fan_drive_output_n,
   input  wire logic [7:0]              tach_input_options,
   input  wire logic [NUM_DRIVES*8-1:0] drive_output_options,
   input  wire logic [1:0]              drive_link_select,
   // Byte reads
   input  wire logic                    read_low_strobe,
   input  wire logic                    read_high_strobe,
   input  wire logic [7:0]              reading_low_byte,
   input  wire logic [7:0]              reading_high_byte,
   // Status
   input  wire logic [15:0]             tach_period_reading,
   input  wire logic                    fan_stalled,
   input  wire logic                    fan_slow
);
   // ----------------------------------------------------------------
   // Helper state
   // ----------------------------------------------------------------
   logic       live;
   logic       hi_frozen;
   logic       next_hi_frozen;
   logic [9:0] idle_cnt;
   logic [9:0] next_idle_cnt;
   always_comb begin
      next_hi_frozen = hi_frozen;
      if (read_low_strobe) begin
         next_hi_frozen = 1'h1;
      end else if (read_high_strobe) begin
         next_hi_frozen = 1'h0;
      end
      // Over two ref ticks of gated drive, so in-flight updates have landed
      next_idle_cnt = 10'h000;
      if (tach_input_options[0] && !fan_drive_output_n[drive_link_select]) begin
         next_idle_cnt = (idle_cnt == 10'h3FF) ? idle_cnt : idle_cnt + 10'h001;
      end
   end
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         live      <= 1'h0;
         hi_frozen <= 1'h0;
         idle_cnt  <= 10'h000;
      end else begin
         live      <= 1'h1;
         hi_frozen <= next_hi_frozen;
         idle_cnt  <= next_idle_cnt;
      end
   end
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   chk_reset_reading_ones: assert property ($rose(reset_n) |-> tach_period_reading == 16'hFFFF)
      else $error("reading not all ones at reset release");
   chk_stall_all_ones: assert property (fan_stalled |-> tach_period_reading == 16'hFFFF)
      else $error("stalled fan without all-ones reading");
   chk_slow_code_select: assert property ($rose(fan_slow) |->
      tach_period_reading == (tach_input_options[5] ? 16'hFFFF : 16'hFFFE))
      else $error("slow fan code does not follow select bit");
   chk_flags_exclusive: assert property (!(fan_stalled && fan_slow))
      else $error("stalled and slow flagged together");
   chk_count_clears_flags: assert property (tach_period_reading < 16'hFFFE |->
      !fan_stalled && !fan_slow)
      else $error("valid count with a fault flag");
   chk_high_byte_frozen: assert property (hi_frozen && $past(hi_frozen) |->
      $stable(reading_high_byte))
      else $error("high byte moved while frozen");
   chk_high_byte_tracks: assert property (live && !hi_frozen && !$past(hi_frozen) |->
      {reading_high_byte, 8'h00} == ($past(tach_period_reading) & 16'hFF00))
      else $error("high byte not tracking reading");
   chk_gated_no_update: assert property (idle_cnt >= 10'h1F4 |->
      $stable(tach_period_reading))
      else $error("reading changed while drive low in pulsed mode");
   cov_stall: cover property ($rose(fan_stalled));
   cov_slow: cover property ($rose(fan_slow));
   cov_unfreeze: cover property ($fell(hi_frozen));
endmodule // fan_tach_measure_checker
`default_nettype wire

/* sim/tb.sv */
// Self-checking testbench for the fan speed measurement block
`timescale 1ns/100ps
`default_nettype none
module tb;
   import fan_tach_pkg::*;
   logic        core_clk;
   logic        reset_n;
   logic        drive;
   logic        rd_lo;
   logic        rd_hi;
   logic [7:0]  topt;
   logic [7:0]  lo_b;
   logic [7:0]  hi_b;
   logic [15:0] half;
   logic [15:0] rdg;
   logic [23:0] dopt;
   logic [15:0] expd;
   logic        stalled;
   logic        slow;
   logic        tach;
   int          errors;
   int          n_checks;
   int          cycles = 0;
   // Pulsed rows: tach half period in ticks, options, window, flags {stalled, slow}, update code
   // Row 5 rises inside the interval loaded by row 4, so its slower fan must not be measured
   int          m2_half [7] = '{0, 16, 16, 16, 4, 8, 8};
   logic [7:0]  m2_opt  [7] = '{8'h01, 8'h01, 8'h21, 8'h41, 8'h01, 8'h01, 8'h19};
   logic [15:0] m2_lo   [7] = '{16'hFFFF, 16'hFFFE, 16'hFFFF, 16'hFFFF,
                                16'h0003, 16'h0003, 16'h0003};
   logic [15:0] m2_hi   [7] = '{16'hFFFF, 16'hFFFE, 16'hFFFF, 16'hFFFF,
                                16'h0005, 16'h0005, 16'h0005};
   logic [1:0]  m2_flag [7] = '{2'h2, 2'h1, 2'h1, 2'h2, 2'h0, 2'h0, 2'h0};
   logic [1:0]  m2_upd  [7] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h2, 2'h0, 2'h0};
   logic [3:0]  nedge   [4] = '{EDGES_2, EDGES_3, EDGES_5, EDGES_9};

   fan_tach_model fan (.core_clk(core_clk), .powered(drive), .half_cycles(half),
      .fan_speed_input_n(tach));
   fan_tach_speed_measure #(.NUM_DRIVES(3), .TICKS_300MS(4), .TICKS_500MS(6),
      .TICKS_1000MS(30)) DUT (
      .core_clk(core_clk), .reset_n(reset_n), .fan_speed_input_n(tach),
      .fan_drive_output_n({drive, 2'h0}), .tach_input_options(topt),
      .drive_output_options(dopt), .drive_link_select(2'h2),
      .read_low_strobe(rd_lo), .read_high_strobe(rd_hi), .reading_low_byte(lo_b),
      .reading_high_byte(hi_b), .tach_period_reading(rdg), .fan_stalled(stalled),
      .fan_slow(slow));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   always #25 core_clk = ~core_clk;
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp_v);
      n_checks++;
      if (seen !== exp_v) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp_v, seen);
      end
   endtask
   function automatic logic [15:0] in_rng(input logic [15:0] v, input logic [15:0] lo,
      input logic [15:0] hi);
      return (v >= lo && v <= hi) ? 16'h0001 : 16'h0000;
   endfunction
   task automatic wait_ticks(input int n);
      repeat (n * REF_DIV) @(posedge core_clk);
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Ceiling sits just above the planned run of about 95k cycles
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 99000) begin
         errors++;
         print_verdict();
      end
   end

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      core_clk = 1'h0; reset_n = 1'h0; drive = 1'h0; rd_lo = 1'h0; rd_hi = 1'h0;
      topt = 8'h00; half = 16'h0000; errors = 0; n_checks = 0;
      dopt = 24'h000000;
      repeat (5) @(posedge core_clk);
      check("reset_reading", rdg, 16'hFFFF);
      check("reset_bytes_flags", {hi_b, lo_b} | {14'h0000, stalled, slow}, 16'h0000);
      reset_n <= 1'h1;
      @(posedge core_clk) rd_lo <= 1'h1;
      @(posedge core_clk) rd_lo <= 1'h0;
      drive <= 1'h1;
      half  <= 16'(4 * REF_DIV);
      for (int c = 0; c < 4; c++) begin
         topt <= 8'(c * 2);
         expd = 16'((nedge[c] - 1) * 4);
         wait_ticks((2 * nedge[c] + 2) * 4);
         check("mode1_count", in_rng(rdg, expd - 16'h0001, expd + 16'h0001), 16'h0001);
         check("mode1_flags", {14'h0000, stalled, slow}, 16'h0000);
         if (c == 0) begin
            check("high_byte_frozen", {8'h00, hi_b}, 16'h00FF);
            @(posedge core_clk) rd_hi <= 1'h1;
            @(posedge core_clk) rd_hi <= 1'h0;
            repeat (2) @(posedge core_clk);
            check("high_byte_released", {8'h00, hi_b}, 16'h0000);
            check("low_byte", in_rng({8'h00, lo_b}, expd - 16'h0001, expd + 16'h0001), 16'h0001);
         end
      end
      for (int r = 0; r < 7; r++) begin
         topt  <= m2_opt[r];
         dopt  <= {6'h00, m2_upd[r], 16'h0000};
         drive <= 1'h0;
         half  <= 16'h0000;
         wait_ticks(8);
         drive <= 1'h1;
         half  <= 16'(m2_half[r] * REF_DIV);
         wait_ticks(24);
         drive <= 1'h0;
         wait_ticks(3);
         check("pulsed_reading", in_rng(rdg, m2_lo[r], m2_hi[r]), 16'h0001);
         check("pulsed_flags", {14'h0000, stalled, slow}, {14'h0000, m2_flag[r]});
      end
      print_verdict();
   end
endmodule // tb

bind fan_tach_speed_measure fan_tach_measure_checker #(.NUM_DRIVES(NUM_DRIVES)) chk (
   .core_clk(core_clk), .reset_n(reset_n), .fan_speed_input_n(fan_speed_input_n),
   .fan_drive_output_n(fan_drive_output_n), .tach_input_options(tach_input_options),
   .drive_output_options(drive_output_options), .drive_link_select(drive_link_select),
   .read_low_strobe(read_low_strobe), .read_high_strobe(read_high_strobe),
   .reading_low_byte(reading_low_byte), .reading_high_byte(reading_high_byte),
   .tach_period_reading(tach_period_reading), .fan_stalled(fan_stalled), .fan_slow(fan_slow));
`default_nettype wire
